// file: hw/wsc_wake_regs.sv
// Wake source control registers with serial port and wake gating
// Notes on behaviour
// R1 - Bit 7 enables second timer cyclic wake
// R2 - Bit 6 enables first timer cyclic wake
// R3 - Reserved bits read zero, ignore writes
// R4 - Bit 2 disables watchdog in stop; hardware-updatable
// R5 - Global interrupt bit widens interrupt to status
// R6 - Measure select ignores inputs one, two
// R7 - Bits 2:0 enable wake inputs three..one
// R8 - Bus transceivers wake only when wake capable
// R9 - Fail-safe entry forces wake register patterns
// R10 - External control resets 0x07, restart keeps all bits
// R11 - Two-bit bias field per wake input
// R12 - Bias, filter clear on reset, keep on restart
// R13 - Filter register holds three two-bit fields
// R14 - Filter code selects static or cyclic filtering
// R15 - Events flag and request only when enabled
`timescale 1ns/1ps
`default_nettype none
module wsc_wake_regs
    import wsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic softReset,
    input wire logic restartEntry,
    input wire logic failSafeEntry,
    input wire logic normalMode,
    input wire logic spiCsn,
    input wire logic spiClk,
    input wire logic spiDataIn,
    output logic spiDataOut,
    output logic spiDataOutEn,
    input wire logic wdStopHwUpdate,
    input wire logic wdStopHwValue,
    input wire wsc_events_t events,
    input wire wsc_bus_modes_t busModes,
    input wire logic statusEvent,
    input wire logic [7:0] wakeFlagClear,
    output logic [7:0] wakeFlags,
    output logic wakeRequest,
    output logic intRequest,
    output logic [1:0] timerWakeEnable,
    output logic watchdogStopDisable,
    output logic measureActive,
    output logic [2:0] inputWakeEnable,
    output logic [5:0] inputBias,
    output logic [5:0] inputFilter,
    output logic busCtrlFailSafeLoad
);
    logic [7:0] intWakeCtrl_reg;
    logic [7:0] extWakeCtrl_reg;
    logic [7:0] biasSel_reg;
    logic [7:0] filterSel_reg;
    logic [2:0] pinIn;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic [2:0] pinStable_reg;
    logic [2:0] pinPrev_reg;
    logic [4:0] bitCount_reg;
    logic [15:0] shiftIn_reg;
    logic [7:0] shiftOut_reg;
    logic [7:0] readData;
    logic csnHigh;
    logic clkRise;
    logic clkFall;
    logic csnRise;
    logic writeStrobe;
    logic [6:0] frameAddr;
    logic [6:0] midAddr;
    logic [7:0] frameData;
    logic [2:0] inputEnEff;
    wsc_events_t gated;

    assign pinIn = {spiDataIn, spiClk, spiCsn};

    // Three-stage synchronisers; a change counts once stages 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    // Idle levels, so no false edge follows reset
                    sync1_reg[gi] <= SPI_PIN_IDLE[gi];
                    sync2_reg[gi] <= SPI_PIN_IDLE[gi];
                    sync3_reg[gi] <= SPI_PIN_IDLE[gi];
                    pinStable_reg[gi] <= SPI_PIN_IDLE[gi];
                    pinPrev_reg[gi] <= SPI_PIN_IDLE[gi];
                end else begin
                    sync1_reg[gi] <= pinIn[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        pinStable_reg[gi] <= sync3_reg[gi];
                    end
                    pinPrev_reg[gi] <= pinStable_reg[gi];
                end
            end
        end
    endgenerate

    assign csnHigh = pinStable_reg[0];
    assign csnRise = pinStable_reg[0] & ~pinPrev_reg[0];
    assign clkRise = pinStable_reg[1] & ~pinPrev_reg[1] & ~csnHigh;
    assign clkFall = ~pinStable_reg[1] & pinPrev_reg[1] & ~csnHigh;
    assign frameAddr = shiftIn_reg[6:0];
    assign frameData = shiftIn_reg[15:8];
    // After seven bits the address has shifted into the top bits
    assign midAddr = shiftIn_reg[15:9];
    // Only a complete frame with the write bit set takes effect
    assign writeStrobe = csnRise & (bitCount_reg == FRAME_BITS)
        & shiftIn_reg[7];

    // Read mux on the mid-frame address; reserved bits read zero
    always_comb begin
        if (midAddr == INT_WAKE_CTRL_ADDR) begin
            readData = intWakeCtrl_reg;
        end else if (midAddr == EXT_WAKE_CTRL_ADDR) begin
            readData = extWakeCtrl_reg;
        end else if (midAddr == BIAS_SEL_ADDR) begin
            readData = biasSel_reg;
        end else if (midAddr == FILTER_SEL_ADDR) begin
            readData = filterSel_reg;
        end else begin
            readData = 8'h00;
        end
    end

    // Frame receive: sample on rising clock, count bits
    // Counting one past 16 marks a long frame, so it never writes
    always_ff @(posedge sys_clk) begin
        if (rst || csnHigh) begin
            bitCount_reg <= 5'h00;
            if (rst) begin
                shiftIn_reg <= 16'h0000;
            end
        end else if (clkRise && bitCount_reg <= FRAME_BITS) begin
            shiftIn_reg <= {pinStable_reg[2], shiftIn_reg[15:1]};
            bitCount_reg <= bitCount_reg + 5'h01;
        end
    end

    // Answer shifting: the addressed register goes out during data byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shiftOut_reg <= 8'h00;
            spiDataOut <= 1'b0;
            spiDataOutEn <= 1'b0;
        end else begin
            spiDataOutEn <= ~csnHigh;
            if (csnHigh) begin
                spiDataOut <= 1'b0;
            end else if (clkFall && bitCount_reg == FRAME_ADDR_BITS) begin
                // Address complete, the address sits in the top bits now
                shiftOut_reg <= readData;
                spiDataOut <= 1'b0;
            end else if (clkFall && bitCount_reg > FRAME_ADDR_BITS) begin
                spiDataOut <= shiftOut_reg[0];
                shiftOut_reg <= {1'b0, shiftOut_reg[7:1]};
            end
        end
    end

    // Internal wake control; hardware update of bit 2 beats a write
    always_ff @(posedge sys_clk) begin
        if (rst || softReset) begin
            intWakeCtrl_reg <= INT_WAKE_CTRL_RST;
        end else begin
            if (restartEntry) begin
                intWakeCtrl_reg <= intWakeCtrl_reg & INT_WAKE_CTRL_KEEP;
            end else if (writeStrobe && frameAddr == INT_WAKE_CTRL_ADDR) begin
                intWakeCtrl_reg <= frameData & INT_WAKE_CTRL_MASK; // see R3
            end
            if (wdStopHwUpdate) begin
                intWakeCtrl_reg[WD_STOP_DISABLE_BIT] <= wdStopHwValue; // see R4
            end
        end
    end

    // External wake control; fail-safe entry sets all three input enable bits
    always_ff @(posedge sys_clk) begin
        if (rst || softReset) begin
            extWakeCtrl_reg <= EXT_WAKE_CTRL_RST; // see R10
        end else if (failSafeEntry) begin
            extWakeCtrl_reg <= (extWakeCtrl_reg & EXT_WAKE_FS_KEEP)
                | EXT_WAKE_FS_SET; // see R9
        end else if (restartEntry) begin
            extWakeCtrl_reg <= extWakeCtrl_reg & EXT_WAKE_CTRL_KEEP; // see R10
        end else if (writeStrobe && frameAddr == EXT_WAKE_CTRL_ADDR) begin
            extWakeCtrl_reg <= frameData & EXT_WAKE_CTRL_MASK; // see R3
        end
    end

    // Bias and filter selection; a restart leaves them untouched
    always_ff @(posedge sys_clk) begin
        if (rst || softReset) begin
            biasSel_reg <= BIAS_SEL_RST; // see R12
            filterSel_reg <= FILTER_SEL_RST; // see R12
        end else if (writeStrobe && !restartEntry) begin
            if (frameAddr == BIAS_SEL_ADDR) begin
                biasSel_reg <= frameData & CFG6_MASK; // see R11
            end
            if (frameAddr == FILTER_SEL_ADDR) begin
                filterSel_reg <= frameData & CFG6_MASK; // see R13
            end
        end
    end

    // Effective input enables with the measurement override
    assign inputEnEff = extWakeCtrl_reg[2:0]
        & {1'b1, {2{~extWakeCtrl_reg[WAKE_MEAS_BIT]}}}; // see R6 R7
    always_comb begin
        gated.wakeInput = events.wakeInput & inputEnEff; // see R15
        gated.timer = events.timer
            & {intWakeCtrl_reg[SECOND_TIMER_WAKE_BIT],
               intWakeCtrl_reg[FIRST_TIMER_WAKE_BIT]}; // see R1 R2
        gated.can = events.can
            & (busModes.canMode[1:0] == CAN_WAKE_CAPABLE); // see R8
        gated.lin1 = events.lin1 & (busModes.lin1Mode == LIN_WAKE_CAPABLE);
        gated.lin2 = events.lin2 & (busModes.lin2Mode == LIN_WAKE_CAPABLE);
    end

    // Sticky wake flags; a new event wins over a clear
    always_ff @(posedge sys_clk) begin
        if (rst || softReset) begin
            wakeFlags <= 8'h00;
        end else begin
            wakeFlags <= (wakeFlags & ~wakeFlagClear) | gated; // see R15
        end
    end

    // Requests: wake on any gated event, interrupt widened by global bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wakeRequest <= 1'b0;
            intRequest <= 1'b0;
            busCtrlFailSafeLoad <= 1'b0;
        end else begin
            wakeRequest <= |gated;
            intRequest <= (|gated) | (statusEvent
                & extWakeCtrl_reg[INT_GLOBAL_BIT]); // see R5
            busCtrlFailSafeLoad <= failSafeEntry; // see R9
        end
    end

    // Configuration outputs, registered; measure gated by normal mode, input enables after the override
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timerWakeEnable <= 2'h0;
            watchdogStopDisable <= 1'b0;
            measureActive <= 1'b0;
            inputWakeEnable <= 3'h0;
            inputBias <= 6'h00;
            inputFilter <= 6'h00;
        end else begin
            timerWakeEnable <= {intWakeCtrl_reg[SECOND_TIMER_WAKE_BIT],
                intWakeCtrl_reg[FIRST_TIMER_WAKE_BIT]}; // see R1 R2
            watchdogStopDisable <= intWakeCtrl_reg[WD_STOP_DISABLE_BIT];
            measureActive <= extWakeCtrl_reg[WAKE_MEAS_BIT] & normalMode;
            inputWakeEnable <= inputEnEff; // see R7
            inputBias <= biasSel_reg[5:0]; // see R11
            inputFilter <= filterSel_reg[5:0]; // see R14
        end
    end
endmodule // wsc_wake_regs
`default_nettype wire

// file: hw/wsc_pkg.sv
// Package for the wake source control register bank
package wsc_pkg;
    // Register offsets on the serial control port
    localparam logic [6:0] INT_WAKE_CTRL_ADDR = 7'h06;
    localparam logic [6:0] EXT_WAKE_CTRL_ADDR = 7'h07;
    localparam logic [6:0] BIAS_SEL_ADDR = 7'h08;
    localparam logic [6:0] FILTER_SEL_ADDR = 7'h09;
    // Reset values after power-on or soft reset
    localparam logic [7:0] INT_WAKE_CTRL_RST = 8'h00;
    localparam logic [7:0] EXT_WAKE_CTRL_RST = 8'h07;
    localparam logic [7:0] BIAS_SEL_RST = 8'h00;
    localparam logic [7:0] FILTER_SEL_RST = 8'h00;
    // Writable bits per register, reserved bits stay zero
    localparam logic [7:0] INT_WAKE_CTRL_MASK = 8'hC4;
    localparam logic [7:0] EXT_WAKE_CTRL_MASK = 8'hA7;
    localparam logic [7:0] CFG6_MASK = 8'h3F;
    // Bits kept across a restart
    localparam logic [7:0] INT_WAKE_CTRL_KEEP = 8'hC0;
    localparam logic [7:0] EXT_WAKE_CTRL_KEEP = 8'hA7;
    // Fail-safe patterns: kept bits and forced ones
    localparam logic [7:0] EXT_WAKE_FS_KEEP = 8'hA0;
    localparam logic [7:0] EXT_WAKE_FS_SET = 8'h07;
    localparam logic [7:0] BUS_CTRL1_FS_KEEP = 8'hE0;
    localparam logic [7:0] BUS_CTRL1_FS_SET = 8'h09;
    localparam logic [7:0] BUS_CTRL2_FS_VAL = 8'h01;
    // Field positions
    localparam int SECOND_TIMER_WAKE_BIT = 7;
    localparam int FIRST_TIMER_WAKE_BIT = 6;
    localparam int WD_STOP_DISABLE_BIT = 2;
    localparam int INT_GLOBAL_BIT = 7;
    localparam int WAKE_MEAS_BIT = 5;
    // Bus mode encodings meaning wake capable
    localparam logic [1:0] CAN_WAKE_CAPABLE = 2'h1;
    localparam logic [1:0] LIN_WAKE_CAPABLE = 2'h1;
    // Bias and filter field encodings
    typedef enum logic [1:0] {
        BIAS_NONE, BIAS_PULL_DOWN, BIAS_PULL_UP, BIAS_AUTO
    } wsc_bias_t;
    typedef enum logic [1:0] {
        FLT_STATIC_16US, FLT_STATIC_64US, FLT_CYCLIC_T1, FLT_CYCLIC_T2
    } wsc_filter_t;
    // Serial frame layout, least significant bit first
    localparam logic [4:0] FRAME_ADDR_BITS = 5'h07;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    // Idle levels of the port pins {data, clock, csn}
    localparam logic [2:0] SPI_PIN_IDLE = 3'h1;
    // Detected wake events, one-cycle pulses
    typedef struct packed {
        logic [2:0] wakeInput;
        logic [1:0] timer;
        logic can;
        logic lin1;
        logic lin2;
    } wsc_events_t;
    // Bus transceiver mode fields seen by this block
    typedef struct packed {
        logic [2:0] canMode;
        logic [1:0] lin1Mode;
        logic [1:0] lin2Mode;
    } wsc_bus_modes_t;
endpackage

// file: testbench/wsc_host_model.sv
// Host side of the serial control port, one frame per call
`timescale 1ns/1ps
`default_nettype none
module wsc_host_model (
    input wire logic sys_clk,
    input wire logic spiDataOut,
    output logic spiCsn,
    output logic spiClk,
    output logic spiDataIn
);
    localparam int HALF = 6; // Above the five-cycle minimum half period
    initial begin
        spiCsn = 1'b1;
        spiClk = 1'b0;
        spiDataIn = 1'b0;
    end
    // LSB first: address, write flag, data; read bits come back after bit 7
    task automatic xfer(input logic [6:0] addr, input logic wr,
            input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {wdata, wr, addr};
        rdata = 8'h00;
        @(negedge sys_clk);
        spiCsn = 1'b0;
        repeat (HALF) @(negedge sys_clk);
        for (int i = 0; i < 16; i++) begin
            spiDataIn = frame[i];
            repeat (HALF) @(negedge sys_clk);
            if (i >= 8) rdata[i - 8] = spiDataOut;
            spiClk = 1'b1;
            repeat (HALF) @(negedge sys_clk);
            spiClk = 1'b0;
        end
        repeat (HALF) @(negedge sys_clk);
        spiCsn = 1'b1;
        spiDataIn = ~spiDataIn; // Released line never shows a stale bit
        repeat (10) @(negedge sys_clk); // Write lands, csn gap kept
    endtask
endmodule // wsc_host_model
`default_nettype wire

// file: testbench/wsc_wake_regs_sva.sv
// Checker for the wake source control register bank
`timescale 1ns/1ps
`default_nettype none
module wsc_wake_regs_sva
    import wsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic softReset,
    input wire logic restartEntry,
    input wire logic failSafeEntry,
    input wire wsc_events_t events,
    input wire wsc_bus_modes_t busModes,
    input wire logic statusEvent,
    input wire logic [7:0] wakeFlags,
    input wire logic wakeRequest,
    input wire logic intRequest,
    input wire logic measureActive,
    input wire logic [2:0] inputWakeEnable,
    input wire logic [5:0] inputBias,
    input wire logic [5:0] inputFilter,
    input wire logic [1:0] timerWakeEnable,
    input wire logic busCtrlFailSafeLoad
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_meas_override;
        measureActive |-> inputWakeEnable[1:0] == 2'h0;
    endproperty
    a_meas_override: assert property (p_meas_override)
        else $error("input one or two enabled while measuring");
    property p_wake_cause;
        wakeRequest |-> $past(events) != '0;
    endproperty
    a_wake_cause: assert property (p_wake_cause)
        else $error("wake request without an event");
    property p_int_cause;
        intRequest |-> ($past(events) != '0 || $past(statusEvent));
    endproperty
    a_int_cause: assert property (p_int_cause)
        else $error("interrupt without any event");
    property p_flag_cause;
        (wakeFlags & ~$past(wakeFlags) & ~$past(events)) == 8'h00;
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("wake flag set without its event");
    property p_can_gate;
        $rose(wakeFlags[2]) |-> $past(busModes.canMode[1:0]) == 2'h1;
    endproperty
    a_can_gate: assert property (p_can_gate)
        else $error("bus flag set while not wake capable");
    property p_fs_load;
        failSafeEntry |=> busCtrlFailSafeLoad;
    endproperty
    a_fs_load: assert property (p_fs_load)
        else $error("bus fail-safe load missing");
    property p_fs_wake;
        failSafeEntry |-> ##2 inputWakeEnable[2];
    endproperty
    a_fs_wake: assert property (p_fs_wake)
        else $error("input three not enabled after fail-safe");
    property p_soft;
        softReset |-> ##2 (inputWakeEnable == 3'h7 && inputBias == 6'h00
            && inputFilter == 6'h00 && timerWakeEnable == 2'h0);
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset values wrong");
    property p_restart;
        restartEntry |-> ##2 (inputBias == $past(inputBias, 2)
            && inputFilter == $past(inputFilter, 2));
    endproperty
    a_restart: assert property (p_restart)
        else $error("bias or filter lost on restart");
endmodule // wsc_wake_regs_sva
`default_nettype wire

// file: testbench/test_wsc_wake_regs.sv
// Self-checking bench for the wake source control register bank
`timescale 1ns/1ps
`default_nettype none
module test_wsc_wake_regs
    import wsc_pkg::*;
;
    logic sys_clk, rst, normalMode, wdStopHwValue, statusEvent;
    logic spiCsn, spiClk, spiDataIn, spiDataOut, spiDataOutEn;
    logic softReset, restartEntry, failSafeEntry, wdStopHwUpdate;
    logic wakeRequest, intRequest, watchdogStopDisable, measureActive;
    logic busCtrlFailSafeLoad;
    logic [3:0] pls;
    logic [7:0] wakeFlagClear, wakeFlags, rdv;
    logic [2:0] inputWakeEnable;
    logic [1:0] timerWakeEnable;
    logic [5:0] inputBias, inputFilter;
    wsc_events_t events;
    wsc_bus_modes_t busModes;
    int bad_count = 0, n_compared = 0, seed = 90, cycles = 0;
    logic oeSeen = 1'b0;
    // Remembers that the data output was ever driven
    always @(posedge sys_clk) begin
        if (spiDataOutEn === 1'b1) oeSeen <= 1'b1;
    end
    assign {softReset, restartEntry, failSafeEntry, wdStopHwUpdate} = pls;
    wsc_wake_regs i_wsc_wake_regs (.sys_clk, .rst, .softReset,
        .restartEntry, .failSafeEntry, .normalMode, .spiCsn, .spiClk,
        .spiDataIn, .spiDataOut, .spiDataOutEn, .wdStopHwUpdate,
        .wdStopHwValue, .events, .busModes, .statusEvent, .wakeFlagClear,
        .wakeFlags, .wakeRequest, .intRequest, .timerWakeEnable,
        .watchdogStopDisable, .measureActive, .inputWakeEnable, .inputBias,
        .inputFilter, .busCtrlFailSafeLoad);
    wsc_host_model i_wsc_host_model (.sys_clk, .spiDataOut, .spiCsn,
        .spiClk, .spiDataIn);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the roughly 21000 cycles needed
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_wsc_host_model.xfer(a, 1'b1, d, rdv);
    endtask
    // Read one register and compare all eight bits
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        i_wsc_host_model.xfer(a, 1'b0, 8'h00, rdv);
        check("register read", e, rdv);
    endtask
    task automatic rd_all(input logic [7:0] a, b, c, d);
        rd(INT_WAKE_CTRL_ADDR, a);
        rd(EXT_WAKE_CTRL_ADDR, b);
        rd(BIAS_SEL_ADDR, c);
        rd(FILTER_SEL_ADDR, d);
    endtask
    task automatic pulse(input logic [3:0] p);
        @(negedge sys_clk);
        pls = p;
        @(negedge sys_clk);
        pls = 4'h0;
    endtask
    // Clear flags, fire one cycle of events, sample the outcome
    task automatic stim(input logic [7:0] ev, input logic st,
            output logic [7:0] fl, output logic wq, iq);
        @(negedge sys_clk);
        wakeFlagClear = 8'hFF;
        @(negedge sys_clk);
        wakeFlagClear = 8'h00;
        events = ev;
        statusEvent = st;
        @(negedge sys_clk);
        events = '0;
        statusEvent = 1'b0;
        fl = wakeFlags;
        wq = wakeRequest;
        iq = intRequest;
    endtask
    // Which event bits may raise a flag under a given setup
    function automatic logic [7:0] flag_en(input logic [7:0] ec, ic,
            input wsc_bus_modes_t bm);
        flag_en[7:5] = ec[5] ? {ec[2], 2'b00} : ec[2:0];
        flag_en[4:3] = ic[7:6];
        flag_en[2] = bm.canMode[1:0] == 2'h1;
        flag_en[1] = bm.lin1Mode == 2'h1;
        flag_en[0] = bm.lin2Mode == 2'h1;
    endfunction
    initial begin
        logic [7:0] ic, ec, bc, fc, ev, fl, en;
        logic wq, iq, st;
        rst = 1'b1;
        pls = 4'h0;
        {normalMode, wdStopHwValue, statusEvent} = 3'h4;
        events = '0;
        busModes = '0;
        wakeFlagClear = 8'h00;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        rd_all(8'h00, 8'h07, 8'h00, 8'h00);
        wr(7'h0A, 8'h5A);
        rd(7'h0A, 8'h00);
        check("oe idle", 8'h00, spiDataOutEn);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            ic = (i == 1) ? 8'hFF : 8'($random(seed));
            ec = (i == 0) ? 8'hFF : 8'($random(seed));
            bc = (i < 4) ? {2'b11, {3{i[1:0]}}} : 8'($random(seed));
            fc = (i < 4) ? {2'b11, {3{i[1:0]}}} : 8'($random(seed));
            busModes = 7'($random(seed));
            ev = 8'($random(seed));
            st = 1'($random(seed));
            normalMode = ~i[0];
            wr(INT_WAKE_CTRL_ADDR, ic);
            wr(EXT_WAKE_CTRL_ADDR, ec);
            wr(BIAS_SEL_ADDR, bc);
            wr(FILTER_SEL_ADDR, fc);
            rd_all(ic & 8'hC4, ec & 8'hA7, bc & 8'h3F, fc & 8'h3F);
            en = flag_en(ec, ic, busModes);
            check("bias", bc & 8'h3F, {2'b00, inputBias});
            check("filter", fc & 8'h3F, {2'b00, inputFilter});
            check("timers", ic[7:6], timerWakeEnable);
            check("measure", ec[5] & ~i[0], measureActive);
            check("inputs", en[7:5], inputWakeEnable);
            stim(ev, st, fl, wq, iq);
            check("flags", ev & en, fl);
            check("wake", |(ev & en), wq);
            check("int", |(ev & en) | (st & ec[7]), iq);
        end
        $display("test random setups done");
        wr(INT_WAKE_CTRL_ADDR, 8'hC4);
        check("wd by port", 8'h01, watchdogStopDisable);
        wr(EXT_WAKE_CTRL_ADDR, 8'hA5);
        pulse(4'h4);
        rd(INT_WAKE_CTRL_ADDR, 8'hC0);
        rd(EXT_WAKE_CTRL_ADDR, 8'hA5);
        rd(BIAS_SEL_ADDR, bc & 8'h3F);
        rd(FILTER_SEL_ADDR, fc & 8'h3F);
        check("wd restart", 8'h00, watchdogStopDisable);
        wdStopHwValue = 1'b1;
        pulse(4'h1);
        rd(INT_WAKE_CTRL_ADDR, 8'hC4);
        wr(EXT_WAKE_CTRL_ADDR, 8'hA0);
        pulse(4'h2);
        rd(EXT_WAKE_CTRL_ADDR, 8'hA7);
        pulse(4'h8);
        rd_all(8'h00, 8'h07, 8'h00, 8'h00);
        $display("test restart, fail-safe, soft reset done");
        check("oe seen", 8'h01, oeSeen);
        report_and_stop();
    end
endmodule // test_wsc_wake_regs
`default_nettype wire
bind wsc_wake_regs wsc_wake_regs_sva i_wsc_wake_regs_sva (.sys_clk, .rst,
    .softReset, .restartEntry, .failSafeEntry, .events, .busModes,
    .statusEvent, .wakeFlags, .wakeRequest, .intRequest, .measureActive,
    .inputWakeEnable, .inputBias, .inputFilter, .timerWakeEnable,
    .busCtrlFailSafeLoad);
